//--- slot_status_defines.svh
/*
 * Offsets, field positions, reset values and timing counts of the first
 * card slot status bank. Assumes a 4-bit register address and 8-bit data.
 */
`ifndef SLOT_STATUS_DEFINES_SVH
`define SLOT_STATUS_DEFINES_SVH

`define REG_ADDR_W 4
`define REG_DATA_W 8

`define OFS_STATUS_CONFIG 4'h0
`define OFS_DEBOUNCE_CFG 4'h1
`define OFS_IRQ_MASK 4'h2
`define OFS_IRQ_STATUS 4'h3

`define BIT_FIXED_ONE 7
`define BIT_FIXED_ZERO 6
`define BIT_ANSWER_TIMEOUT 5
`define BIT_PRESENCE_CHANGE 4
`define BIT_OVERCURRENT 3
`define BIT_RANGE_ERROR 2
`define FLD_LEVEL_HI 1
`define FLD_LEVEL_LO 0

`define RST_STATUS_CONFIG 8'h80
`define RST_DEBOUNCE_CFG 3'h0
`define RST_IRQ_MASK 4'h0
`define RST_IRQ_STATUS 4'h0

`define REF_CLK_MHZ 25
`define DEBOUNCE_UNIT_NS 1000
`define DEBOUNCE_UNIT_CYCLES ((`DEBOUNCE_UNIT_NS * `REF_CLK_MHZ + 999) / 1000)
`define ATR_CNT_W_DEFAULT 16
`define DEB_CNT_W_DEFAULT 8

`endif

//--- slot_status_pkg.sv
/*
 * Types shared by the slot status bank and its presence filter.
 * Assumes the constants of slot_status_defines.svh.
 */
package slot_status_pkg;

    typedef enum logic [1:0] {
        LEVEL_OFF,
        LEVEL_1V8,
        LEVEL_3V0,
        LEVEL_5V0
    } supply_level_t;

    typedef enum logic {
        ATR_IDLE,
        ATR_WAIT
    } atr_state_t;

endpackage : slot_status_pkg

//--- presence_if.sv
/*
 * Carrier between the status bank and the card presence filter.
 * Assumes both ends run on the same reference clock.
 */
`timescale 1ns/100ps

interface presence_if;
    logic raw;
    logic [2:0] setting;
    logic filtered;
    logic change;

    modport filt
    (
        input raw,
        input setting,
        output filtered,
        output change
    );

    modport user
    (
        output raw,
        output setting,
        input filtered,
        input change
    );
endinterface : presence_if

//--- presence_filter.sv
/*
 * Card presence filter: three-stage synchroniser, then a debounce counter
 * whose length follows the debounce setting. Assumes the presence pin is
 * asynchronous to ref_clk.
 */
`timescale 1ns/100ps
`include "slot_status_defines.svh"

module presence_filter
    import slot_status_pkg::*;
#(
    parameter int DEB_CNT_W = `DEB_CNT_W_DEFAULT
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    presence_if.filt pf
);

    typedef struct packed {
        logic [2:0] sync;
        logic stable;
        logic [DEB_CNT_W-1:0] cnt;
        logic filtered;
        logic change;
    } filt_t;

    filt_t state_q;
    filt_t state_d;

    function automatic logic [DEB_CNT_W-1:0] deb_threshold(input logic [2:0] setting);
        deb_threshold = DEB_CNT_W'(32'(setting) * `DEBOUNCE_UNIT_CYCLES);
    endfunction : deb_threshold

    always_comb
    begin
        state_d = state_q;
        state_d.change = 1'b0;
        state_d.sync = {state_q.sync[1:0], pf.raw};
        if (state_q.sync[2] == state_q.sync[1])
        begin
            state_d.stable = state_q.sync[2];
        end
        if (state_q.stable != state_q.filtered)
        begin
            if (state_q.cnt >= deb_threshold(pf.setting))
            begin
                state_d.filtered = state_q.stable;
                state_d.change = 1'b1;
                state_d.cnt = '0;
            end
            else
            begin
                state_d.cnt = state_q.cnt + 1'b1;
            end
        end
        else
        begin
            state_d.cnt = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign pf.filtered = state_q.filtered;
    assign pf.change = state_q.change;

endmodule : presence_filter

//--- slot_status_bank.sv
/*
 * Status and configuration byte of the first card slot, with its event
 * detection, a debounce setting register and an interrupt mask/status pair.
 * Assumes pins are asynchronous to ref_clk, while card_clock_tick and
 * answer_wait_start come from logic on ref_clk.
 */
// The plain strobed port and the address map were left to the implementer.
// Notes on behaviour
// - bits 7 and 6 fixed at one, zero
// - answer flag on counter overflow before fall
// - presence flag on each filtered presence change
// - overcurrent flag on detected supply overcurrent
// - reading the byte clears every event flag
// - software may set each event flag
// - writes never clear presence or overcurrent
// - software overcurrent set causes no deactivation
// - range flag set out of range while level is not off, read-clear
// - level field: off, 1.8, 3, 5 volts
// - reset value has only bit 7 set
`timescale 1ns/100ps
`include "slot_status_defines.svh"

module slot_status_bank
    import slot_status_pkg::*;
#(
    parameter int ATR_CNT_W = `ATR_CNT_W_DEFAULT,
    parameter int DEB_CNT_W = `DEB_CNT_W_DEFAULT
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [`REG_ADDR_W-1:0] reg_addr,
    input wire logic [`REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`REG_DATA_W-1:0] reg_rdata,
    output logic irq,
    input wire logic card_io_line,
    input wire logic card_presence_input,
    input wire logic supply_overcurrent_pin,
    input wire logic supply_range_pin,
    input wire logic card_clock_tick,
    input wire logic answer_wait_start,
    output logic [1:0] supply_level_select,
    output logic converter_run,
    output logic deactivate_req,
    output logic card_present
);

    typedef struct packed {
        logic [2:0] io_sync;
        logic io_stable;
        logic [2:0] oc_sync;
        logic oc_stable;
        logic [2:0] rng_sync;
        logic rng_stable;
        logic answer_timeout_flag;
        logic presence_change_flag;
        logic supply_overcurrent_flag;
        logic supply_range_error_flag;
        supply_level_t level;
        logic [2:0] presence_debounce_setting;
        logic [3:0] irq_mask;
        logic [3:0] irq_status;
        atr_state_t atr_state;
        logic [ATR_CNT_W-1:0] atr_cnt;
        logic [`REG_DATA_W-1:0] rdata;
        logic irq;
        logic converter_run;
        logic deactivate;
    } bank_t;

    bank_t state_q;
    bank_t state_d;

    presence_if pres ();

    logic io_fall;
    logic oc_ev;
    logic rng_ev;
    logic answer_ev;
    logic [3:0] hw_ev;
    logic [3:0] sw_set;
    logic rd_status;
    logic wr_status;
    logic wr_debounce;
    logic wr_mask;
    logic wr_irq_status;

    // change counts once second and third stages agree
    function automatic logic settle(input logic [2:0] sync, input logic prev);
        if (sync[2] == sync[1])
        begin
            settle = sync[2];
        end
        else
        begin
            settle = prev;
        end
    endfunction : settle

    // event flags in register order, answer timeout first
    function automatic logic [3:0] flag_vec(input bank_t s);
        flag_vec = {s.answer_timeout_flag, s.presence_change_flag,
                    s.supply_overcurrent_flag, s.supply_range_error_flag};
    endfunction : flag_vec

    function automatic logic [`REG_DATA_W-1:0] status_byte(input bank_t s);
        logic [`REG_DATA_W-1:0] b;
        b = '0;
        b[`BIT_FIXED_ONE] = 1'b1;
        b[`BIT_FIXED_ZERO] = 1'b0;
        b[`BIT_ANSWER_TIMEOUT] = s.answer_timeout_flag;
        b[`BIT_PRESENCE_CHANGE] = s.presence_change_flag;
        b[`BIT_OVERCURRENT] = s.supply_overcurrent_flag;
        b[`BIT_RANGE_ERROR] = s.supply_range_error_flag;
        b[`FLD_LEVEL_HI:`FLD_LEVEL_LO] = s.level;
        status_byte = b;
    endfunction : status_byte

    function automatic logic [`REG_DATA_W-1:0] read_word(
        input logic [`REG_ADDR_W-1:0] addr,
        input bank_t s
    );
        if (addr == `OFS_STATUS_CONFIG)
        begin
            read_word = status_byte(s);
        end
        else if (addr == `OFS_DEBOUNCE_CFG)
        begin
            read_word = {5'h00, s.presence_debounce_setting};
        end
        else if (addr == `OFS_IRQ_MASK)
        begin
            read_word = {4'h0, s.irq_mask};
        end
        else if (addr == `OFS_IRQ_STATUS)
        begin
            read_word = {4'h0, s.irq_status};
        end
        else
        begin
            read_word = 8'h00;
        end
    endfunction : read_word

    assign pres.raw = card_presence_input;
    assign pres.setting = state_q.presence_debounce_setting;

    presence_filter #(
        .DEB_CNT_W(DEB_CNT_W)
    ) u_presence_filter (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pf(pres.filt)
    );

    always_comb
    begin
        state_d = state_q;
        answer_ev = 1'b0;

        // pin synchronisers
        state_d.io_sync = {state_q.io_sync[1:0], card_io_line};
        state_d.io_stable = settle(state_q.io_sync, state_q.io_stable);
        state_d.oc_sync = {state_q.oc_sync[1:0], supply_overcurrent_pin};
        state_d.oc_stable = settle(state_q.oc_sync, state_q.oc_stable);
        state_d.rng_sync = {state_q.rng_sync[1:0], supply_range_pin};
        state_d.rng_stable = settle(state_q.rng_sync, state_q.rng_stable);

        io_fall = state_q.io_stable & ~state_d.io_stable;
        oc_ev = state_d.oc_stable & ~state_q.oc_stable;
        rng_ev = state_d.rng_stable & ~state_q.rng_stable & (state_q.level != LEVEL_OFF);

        // answer-to-reset watchdog
        case (state_q.atr_state)
            ATR_IDLE:
            begin
                if (answer_wait_start)
                begin
                    state_d.atr_state = ATR_WAIT;
                    state_d.atr_cnt = '0;
                end
            end
            ATR_WAIT:
            begin
                if (io_fall)
                begin
                    state_d.atr_state = ATR_IDLE;
                end
                else if (card_clock_tick)
                begin
                    if (&state_q.atr_cnt)
                    begin
                        answer_ev = 1'b1;
                        state_d.atr_state = ATR_IDLE;
                        state_d.atr_cnt = '0;
                    end
                    else
                    begin
                        state_d.atr_cnt = state_q.atr_cnt + 1'b1;
                    end
                end
            end
            default:
            begin
                state_d.atr_state = ATR_IDLE;
            end
        endcase

        hw_ev = {answer_ev, pres.change, oc_ev, rng_ev};

        // register decode
        rd_status = reg_rd && (reg_addr == `OFS_STATUS_CONFIG);
        wr_status = reg_wr && (reg_addr == `OFS_STATUS_CONFIG);
        wr_debounce = reg_wr && (reg_addr == `OFS_DEBOUNCE_CFG);
        wr_mask = reg_wr && (reg_addr == `OFS_IRQ_MASK);
        wr_irq_status = reg_wr && (reg_addr == `OFS_IRQ_STATUS);

        // read data stand one cycle only
        if (reg_rd)
        begin
            state_d.rdata = read_word(reg_addr, state_q);
        end
        else
        begin
            state_d.rdata = 8'h00;
        end

        // ones set, zeros leave flags alone
        if (wr_status)
        begin
            sw_set = reg_wdata[`BIT_ANSWER_TIMEOUT:`BIT_RANGE_ERROR];
        end
        else
        begin
            sw_set = 4'h0;
        end

        if (rd_status)
        begin
            state_d.answer_timeout_flag = 1'b0;
            state_d.presence_change_flag = 1'b0;
            state_d.supply_overcurrent_flag = 1'b0;
            state_d.supply_range_error_flag = 1'b0;
        end

        // software test set, never cleared by a write
        if (sw_set[3])
        begin
            state_d.answer_timeout_flag = 1'b1;
        end
        if (sw_set[2])
        begin
            state_d.presence_change_flag = 1'b1;
        end
        if (sw_set[1])
        begin
            state_d.supply_overcurrent_flag = 1'b1;
        end
        if (sw_set[0])
        begin
            state_d.supply_range_error_flag = 1'b1;
        end

        // hardware set wins over read clear
        if (hw_ev[3])
        begin
            state_d.answer_timeout_flag = 1'b1;
        end
        if (hw_ev[2])
        begin
            state_d.presence_change_flag = 1'b1;
        end
        if (hw_ev[1])
        begin
            state_d.supply_overcurrent_flag = 1'b1;
        end
        if (hw_ev[0])
        begin
            state_d.supply_range_error_flag = 1'b1;
        end

        if (wr_status)
        begin
            state_d.level = supply_level_t'(reg_wdata[`FLD_LEVEL_HI:`FLD_LEVEL_LO]);
        end
        if (wr_debounce)
        begin
            state_d.presence_debounce_setting = reg_wdata[2:0];
        end
        if (wr_mask)
        begin
            state_d.irq_mask = reg_wdata[3:0];
        end

        // interrupt status: write one clears, new event wins
        if (wr_irq_status)
        begin
            state_d.irq_status = state_q.irq_status & ~reg_wdata[3:0];
        end
        state_d.irq_status = state_d.irq_status | hw_ev | sw_set;
        state_d.irq = |(state_d.irq_status & state_d.irq_mask);

        // converter runs on nonzero level with card present
        state_d.converter_run = (state_d.level != LEVEL_OFF) && pres.filtered;

        // software overcurrent set does not deactivate
        state_d.deactivate = oc_ev | rng_ev | sw_set[0];
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= '0;
            state_q.level <= supply_level_t'(2'(`RST_STATUS_CONFIG));
            state_q.presence_debounce_setting <= `RST_DEBOUNCE_CFG;
            state_q.irq_mask <= `RST_IRQ_MASK;
            state_q.irq_status <= `RST_IRQ_STATUS;
            state_q.atr_state <= ATR_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign reg_rdata = state_q.rdata;
    assign irq = state_q.irq;
    assign supply_level_select = state_q.level;
    assign converter_run = state_q.converter_run;
    assign deactivate_req = state_q.deactivate;
    assign card_present = pres.filtered;

endmodule : slot_status_bank

//--- slot_status_sva.sv
/* port checker of the slot status bank
   assumes one clock and an active low reset */
`timescale 1ns/100ps
`include "slot_status_defines.svh"
module slot_status_sva
    import slot_status_pkg::*;
#(
    parameter int ATR_CNT_W = 16,
    parameter int DEB_CNT_W = 8
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [`REG_ADDR_W-1:0] reg_addr,
    input wire logic [`REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`REG_DATA_W-1:0] reg_rdata,
    input wire logic irq,
    input wire logic supply_overcurrent_pin,
    input wire logic supply_range_pin,
    input wire logic [1:0] supply_level_select,
    input wire logic converter_run,
    input wire logic deactivate_req,
    input wire logic card_present
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    property p_fixed_bits;
        $past(reg_rd) && $past(reg_addr) == 4'h0 |-> reg_rdata[7:6] == 2'b10;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bits wrong");

    property p_sw_set;
        reg_wr && reg_addr == 4'h0 ##1 reg_rd && reg_addr == 4'h0 |=>
            (reg_rdata[5:2] & $past(reg_wdata[5:2], 2)) == $past(reg_wdata[5:2], 2);
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("flag not set by write");

    property p_level;
        reg_wr && reg_addr == 4'h0 |=> supply_level_select == $past(reg_wdata[1:0]);
    endproperty
    a_level: assert property (p_level) else $error("level not loaded");

    // converter follows this level and last cycle's presence
    property p_conv_off;
        converter_run == (supply_level_select != 2'h0 && $past(card_present));
    endproperty
    a_conv_off: assert property (p_conv_off) else $error("converter runs");

    property p_sw_range;
        reg_wr && reg_addr == 4'h0 && reg_wdata[2] |=> deactivate_req;
    endproperty
    a_sw_range: assert property (p_sw_range) else $error("no deactivation");

    property p_sw_quiet;
        (!supply_overcurrent_pin && !supply_range_pin) [*8] ##0
            (reg_wr && reg_addr == 4'h0 && !reg_wdata[2]) |=> !deactivate_req;
    endproperty
    a_sw_quiet: assert property (p_sw_quiet) else $error("spurious deactivation");

    property p_oc_pin;
        $rose(supply_overcurrent_pin) |-> ##[1:8] deactivate_req;
    endproperty
    a_oc_pin: assert property (p_oc_pin) else $error("overcurrent ignored");

    property p_range_pin;
        $rose(supply_range_pin) && supply_level_select != 2'h0 |-> ##[1:8] deactivate_req;
    endproperty
    a_range_pin: assert property (p_range_pin) else $error("range error ignored");
endmodule : slot_status_sva

bind slot_status_bank slot_status_sva #(.ATR_CNT_W(ATR_CNT_W), .DEB_CNT_W(DEB_CNT_W)) i_sva (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .supply_overcurrent_pin(supply_overcurrent_pin), .supply_range_pin(supply_range_pin),
    .supply_level_select(supply_level_select), .converter_run(converter_run),
    .deactivate_req(deactivate_req), .card_present(card_present));

//--- card_model.sv
/* stand-in for the card in slot one
   assumes the bench commands insertion and the answer */
`timescale 1ns/100ps
module card_model
(
    input wire logic ref_clk,
    input wire logic inserted,
    input wire logic answer_now,
    output logic card_presence_input,
    output logic card_io_line
);
    logic [2:0] low_cnt_q = 3'h0;
    assign card_presence_input = inserted;
    // io line pulled up unless the card answers
    assign card_io_line = !(inserted && low_cnt_q != 3'h0);
    always @(posedge ref_clk)
    begin
        if (answer_now)
            low_cnt_q <= 3'h7;
        else if (low_cnt_q != 3'h0)
            low_cnt_q <= low_cnt_q - 3'h1;
    end
endmodule : card_model

//--- tb.sv
/* bench of the slot status bank with a card model
   assumes a 25 MHz ref_clk and a short answer counter */
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
    logic ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d, r;
    logic oc_pin = 1'b0, range_pin = 1'b0, tick = 1'b0, wait_start = 1'b0;
    logic inserted = 1'b0, answer_now = 1'b0, io, pres_in, irq, conv, deact, present;
    logic [1:0] level;
    int bad_count = 0, check_count = 0, seed = 32'h9EEC, deact_n = 0, st, n;

    always #20 ref_clk = !ref_clk;
    always @(posedge ref_clk) if (deact) deact_n++;

    card_model i_card (.ref_clk(ref_clk), .inserted(inserted), .answer_now(answer_now),
        .card_presence_input(pres_in), .card_io_line(io));
    slot_status_bank #(.ATR_CNT_W(4)) i_dut (.ref_clk(ref_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .card_io_line(io), .card_presence_input(pres_in),
        .supply_overcurrent_pin(oc_pin), .supply_range_pin(range_pin),
        .card_clock_tick(tick), .answer_wait_start(wait_start),
        .supply_level_select(level), .converter_run(conv), .deactivate_req(deact),
        .card_present(present));

    task wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task rd(input logic [3:0] a, output logic [7:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge ref_clk);
    endtask : rd

    task idle(input int c);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (c) @(posedge ref_clk);
    endtask : idle

    task close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    initial
    begin
        #(40 * 8000);
        bad_count++;
        close_out();
    end

    initial
    begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        st = 8'h80;
        rd(4'h0, r); `CHK("reset byte", st, r)
        $display("test reset done");
        repeat (4)
        begin
            d = 8'($random(seed));
            wr(4'h0, d);
            st = 8'h80 | (st & 8'h3C) | (d & 8'h3F);
            rd(4'h0, r); `CHK("sw set", st, r)
            `CHK("fixed", 2'b10, r[7:6])
            st = st & 8'h83;
            rd(4'h0, r); `CHK("read clear", st, r)
        end
        wr(4'h0, 8'h1F);
        wr(4'h0, 8'h01);
        st = 8'h9D;
        rd(4'h0, r); `CHK("write zero", st, r)
        st = 8'h81;
        $display("test software flags done");
        d = 8'($random(seed)) & 8'h01;
        wr(4'h1, d);
        for (int k = 0; k < 3; k++)
        begin
            inserted <= (k != 1);
            idle(90);
            `CHK("present", k != 1, present)
            rd(4'h0, r); `CHK("presence flag", st | 8'h10, r)
        end
        $display("test presence done");
        for (int lv = 0; lv < 4; lv++)
        begin
            wr(4'h0, 8'(lv));
            idle(3);
            `CHK("level", lv[1:0], level)
            `CHK("converter", lv != 0, conv)
        end
        wr(4'h0, 8'h01);
        $display("test level done");
        for (int k = 0; k < 2; k++)
        begin
            wait_start <= 1'b1;
            idle(1);
            wait_start <= 1'b0;
            answer_now <= (k == 1);
            idle(1);
            answer_now <= 1'b0;
            idle(8);
            repeat (20)
            begin
                tick <= 1'b1;
                idle(1);
                tick <= 1'b0;
                idle(1);
            end
            rd(4'h0, r); `CHK("answer flag", (k == 0) ? 8'hA1 : 8'h81, r)
        end
        $display("test answer done");
        n = deact_n;
        oc_pin <= 1'b1;
        idle(10);
        oc_pin <= 1'b0;
        idle(4);
        `CHK("oc deact", n + 1, deact_n)
        rd(4'h0, r); `CHK("oc flag", 8'h89, r)
        n = deact_n;
        wr(4'h0, 8'h09);
        idle(4);
        `CHK("sw oc deact", n, deact_n)
        rd(4'h0, r); `CHK("sw oc flag", 8'h89, r)
        n = deact_n;
        range_pin <= 1'b1;
        idle(10);
        range_pin <= 1'b0;
        idle(4);
        `CHK("range deact", n + 1, deact_n)
        rd(4'h0, r); `CHK("range flag", 8'h85, r)
        $display("test pins done");
        wr(4'h3, 8'h0F);
        wr(4'h2, 8'h0F);
        wr(4'h0, 8'h21);
        idle(3);
        `CHK("irq on", 1'b1, irq)
        wr(4'h2, 8'h00);
        idle(3);
        `CHK("irq masked", 1'b0, irq)
        rd(4'h3, r); `CHK("irq status", 8'h08, r)
        wr(4'h3, 8'h08);
        wr(4'h2, 8'h0F);
        idle(3);
        `CHK("irq cleared", 1'b0, irq)
        wr(4'hA, 8'hFF);
        rd(4'hA, r); `CHK("unmapped", 8'h00, r)
        rd(4'h0, r); `CHK("after irq", 8'hA1, r)
        $display("test interrupt done");
        close_out();
    end
endmodule : tb
